// >>> src/tap_pkg.sv
// Purpose: Shared constants and types for the burst SRAM test port and its controller
// Assumes: One core clock at 250 MHz on both ends
// Notes:   Instruction codes other than the all-zero one are local choices
package tap_pkg;
    typedef logic [2:0] instr_t;

    // Instruction codes; all unlisted values are reserved
    localparam instr_t INS_EXTEST   = 3'h0;
    localparam instr_t INS_IDCODE   = 3'h1;
    localparam instr_t INS_SAMPLE_Z = 3'h2;
    localparam instr_t INS_SAMPLE   = 3'h4;
    localparam instr_t INS_BYPASS   = 3'h7;

    localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;   // Low instruction bits on capture
    localparam logic       IR_CAPTURE_MSB = 1'h0;   // Top instruction bit on capture
    localparam logic       BYPASS_CAPTURE = 1'h0;

    localparam int IR_W           = 3;
    localparam int ID_W           = 32;
    localparam int BSR_LEN_WIDE   = 73;
    localparam int BSR_LEN_NARROW = 54;
    localparam int TMS_RESET_EDGES = 5;

    // Link clock timing
    localparam int CLK_MHZ      = 250;
    localparam int TCK_MAX_MHZ  = 10;
    localparam int TCK_HALF_CYC = (CLK_MHZ + 2 * TCK_MAX_MHZ - 1) / (2 * TCK_MAX_MHZ);
    localparam int HALF_CNT_W   = 5;

    // Command queue in front of the controller
    localparam int FIFO_W     = 2;
    localparam int FIFO_DEPTH = 16;

    // Sixteen-state controller, one-hot
    typedef enum logic [15:0] {
        ST_RESET      = 16'h0001,
        ST_IDLE       = 16'h0002,
        ST_SEL_DR     = 16'h0004,
        ST_CAPTURE_DR = 16'h0008,
        ST_SHIFT_DR   = 16'h0010,
        ST_EXIT1_DR   = 16'h0020,
        ST_PAUSE_DR   = 16'h0040,
        ST_EXIT2_DR   = 16'h0080,
        ST_UPDATE_DR  = 16'h0100,
        ST_SEL_IR     = 16'h0200,
        ST_CAPTURE_IR = 16'h0400,
        ST_SHIFT_IR   = 16'h0800,
        ST_EXIT1_IR   = 16'h1000,
        ST_PAUSE_IR   = 16'h2000,
        ST_EXIT2_IR   = 16'h4000,
        ST_UPDATE_IR  = 16'h8000
    } tap_state_e;

    // Controller end sequencing
    typedef enum logic [2:0] {
        HS_IDLE = 3'h1,
        HS_LOW  = 3'h2,
        HS_HIGH = 3'h4
    } host_state_e;
endpackage : tap_pkg

// >>> src/tap_link_if.sv
// Purpose: Serial test link between the test port and its controller
// Assumes: The controller makes the test clock; the port only drives data out
// Notes:   Data out is three-state on the board; here it is a value and an enable
`timescale 1ns/1ns
`default_nettype none
interface tap_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;

    // Port end
    modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
    // Controller end
    modport ctl (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface : tap_link_if
`default_nettype wire

// >>> src/sram_tap_device.sv
// Purpose: Boundary-scan test port of a synchronous burst SRAM
// Assumes: Test clock, mode and data arrive asynchronously and are oversampled
// Notes:   Capture-only boundary register; no preload, no drive into the core
`timescale 1ns/1ns
`default_nettype none
module sram_tap_device #(
    parameter bit          WIDE    = 1'b1,
    parameter logic [31:0] ID_WORD = 32'h5A3C_0F01   // Arbitrary identification value
) (
    input  wire logic                              core_clk,
    input  wire logic                              srst,
    tap_link_if.dev                                link,
    input  wire logic [tap_pkg::BSR_LEN_WIDE-1:0]  io_ring,
    output logic                                   outputs_hiz
);
    import tap_pkg::*;

    localparam int BSR_LEN = WIDE ? BSR_LEN_WIDE : BSR_LEN_NARROW;

    // Controller step for one rising test clock edge
    function automatic tap_state_e next_state(input tap_state_e s, input logic tms);
        case (s)
            ST_RESET:      next_state = tms ? ST_RESET   : ST_IDLE;
            ST_IDLE:       next_state = tms ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_DR:     next_state = tms ? ST_SEL_IR  : ST_CAPTURE_DR;
            ST_CAPTURE_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR:   next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR:   next_state = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
            ST_PAUSE_DR:   next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR:   next_state = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
            ST_UPDATE_DR:  next_state = tms ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_IR:     next_state = tms ? ST_RESET   : ST_CAPTURE_IR;
            ST_CAPTURE_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR:   next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR:   next_state = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
            ST_PAUSE_IR:   next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR:   next_state = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
            ST_UPDATE_IR:  next_state = tms ? ST_SEL_DR  : ST_IDLE;
            default:       next_state = ST_RESET;
        endcase
    endfunction : next_state

    // Two-stage synchronisers; third stage of the clock only for edge finding
    logic [2:0]              sync1_q;
    logic [2:0]              sync2_q;
    logic                    tck_prev_q;
    logic [BSR_LEN_WIDE-1:0] ring1_q;
    logic [BSR_LEN_WIDE-1:0] ring2_q;

    always_ff @(posedge core_clk) begin
        sync1_q    <= {link.tck, link.tms, link.tdi};
        sync2_q    <= sync1_q;
        tck_prev_q <= sync2_q[2];
        ring1_q    <= io_ring;
        ring2_q    <= ring1_q;
    end

    wire tck_s    = sync2_q[2];
    wire tms_s    = sync2_q[1];
    wire tdi_s    = sync2_q[0];
    wire tck_rise = tck_s & ~tck_prev_q;
    wire tck_fall = ~tck_s & tck_prev_q;

    // Controller state
    tap_state_e state_q;
    tap_state_e state_d;

    assign state_d = tck_rise ? next_state(state_q, tms_s) : state_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Instruction decode from the active instruction
    instr_t ir_q;
    instr_t ir_sh_q;
    wire    ins_extest = (ir_q == INS_EXTEST);
    wire    ins_samp_z = (ir_q == INS_SAMPLE_Z);
    wire    ins_sample = (ir_q == INS_SAMPLE);
    wire    ins_idcode = (ir_q == INS_IDCODE);
    wire    sel_bsr    = ins_extest | ins_samp_z | ins_sample;
    wire    sel_id     = ins_idcode & ~sel_bsr;
    wire    sel_byp    = ~sel_bsr & ~sel_id;

    wire in_cap_ir = (state_q == ST_CAPTURE_IR);
    wire in_sh_ir  = (state_q == ST_SHIFT_IR);
    wire in_upd_ir = (state_q == ST_UPDATE_IR);
    wire in_cap_dr = (state_q == ST_CAPTURE_DR);
    wire in_sh_dr  = (state_q == ST_SHIFT_DR);
    wire in_reset  = (state_q == ST_RESET);

    // Instruction shift and hold registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ir_q    <= INS_IDCODE;
            ir_sh_q <= INS_IDCODE;
        end else if (tck_rise) begin
            if (in_reset) begin
                ir_q <= INS_IDCODE;
            end else if (in_upd_ir) begin
                ir_q <= ir_sh_q;
            end
            if (in_cap_ir) begin
                ir_sh_q <= {IR_CAPTURE_MSB, IR_CAPTURE_PAT};
            end else if (in_sh_ir) begin
                ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
            end
        end
    end

    // Data registers; update state deliberately does nothing
    logic                    byp_q;
    logic [ID_W-1:0]         id_q;
    logic [BSR_LEN_WIDE-1:0] bsr_q;
    logic [BSR_LEN_WIDE-1:0] bsr_shifted;

    always_comb begin
        for (int i = 0; i < BSR_LEN_WIDE; i++) begin
            if (i == BSR_LEN - 1) begin
                bsr_shifted[i] = tdi_s;
            end else if (i < BSR_LEN - 1) begin
                bsr_shifted[i] = bsr_q[i+1];
            end else begin
                bsr_shifted[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            byp_q <= BYPASS_CAPTURE;
            id_q  <= '0;
            bsr_q <= '0;
        end else if (tck_rise) begin
            if (in_cap_dr && sel_byp) begin
                byp_q <= BYPASS_CAPTURE;
            end else if (in_sh_dr && sel_byp) begin
                byp_q <= tdi_s;
            end
            if (in_cap_dr && sel_id) begin
                id_q <= {ID_WORD[ID_W-1:1], 1'b1};
            end else if (in_sh_dr && sel_id) begin
                id_q <= {tdi_s, id_q[ID_W-1:1]};
            end
            if (in_cap_dr && sel_bsr) begin
                bsr_q <= ring2_q;
            end else if (in_sh_dr && sel_bsr) begin
                bsr_q <= bsr_shifted;
            end
        end
    end

    // Serial output source, exactly one register at a time
    wire dr_lsb  = sel_bsr ? bsr_q[0] : (sel_id ? id_q[0] : byp_q);
    wire out_bit = in_sh_ir ? ir_sh_q[0] : dr_lsb;
    wire shifting = in_sh_ir | in_sh_dr;

    // Serial output changes on the falling test clock edge only
    logic tdo_q;
    logic tdo_oe_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q    <= out_bit;
            tdo_oe_q <= shifting;
        end
    end

    assign link.tdo    = tdo_q;
    assign link.tdo_oe = tdo_oe_q;

    // Memory output float request follows the active instruction
    always_ff @(posedge core_clk) begin
        if (srst) begin
            outputs_hiz <= 1'b0;
        end else begin
            outputs_hiz <= ins_extest | ins_samp_z;
        end
    end
endmodule : sram_tap_device
`default_nettype wire

// >>> src/tap_host.sv
// Purpose: Test controller end: queue of mode/data bits played out on the link
// Assumes: Caller supplies only legal instruction codes
// Notes:   Test clock is a divided core clock, one queued word per test clock
`timescale 1ns/1ns
`default_nettype none
module tap_cmd_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;

    // Handshakes and flags; ready is registered from the next count
    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;
    assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    // Storage and pointers
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_q     <= '0;
            rd_q     <= '0;
            cnt_q    <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_q     <= push ? wr_q + 1'b1 : wr_q;
            rd_q     <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q    <= cnt_d;
            in_ready <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule : tap_cmd_fifo

module tap_host (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic cmd_valid,
    input  wire logic cmd_tms,
    input  wire logic cmd_tdi,
    output logic      cmd_ready,
    output logic      tdo_valid,
    output logic      tdo_bit,
    output logic      tdo_driven,
    tap_link_if.ctl   link
);
    import tap_pkg::*;

    localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(TCK_HALF_CYC - 1);

    logic              q_valid;
    logic [FIFO_W-1:0] q_data;
    logic              q_pop;

    tap_cmd_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) tap_cmd_fifo_i (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (cmd_valid),
        .in_data   ({cmd_tms, cmd_tdi}),
        .in_ready  (cmd_ready),
        .out_valid (q_valid),
        .out_data  (q_data),
        .out_ready (q_pop)
    );

    // Serial data back from the port, two flip-flops first
    logic [1:0] tdo1_q;
    logic [1:0] tdo2_q;

    always_ff @(posedge core_clk) begin
        tdo1_q <= {link.tdo, link.tdo_oe};
        tdo2_q <= tdo1_q;
    end

    host_state_e           hs_q;
    logic [HALF_CNT_W-1:0] cnt_q;
    logic                  tck_q;
    logic                  tms_q;
    logic                  tdi_q;

    wire half_done = (cnt_q == HALF_LAST);
    wire take      = q_valid & ((hs_q == HS_IDLE) | ((hs_q == HS_HIGH) & half_done));
    assign q_pop   = take;   // Queue stalls while a test clock is in flight

    // Sequencer: low half, rising edge with sample, high half
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hs_q       <= HS_IDLE;
            cnt_q      <= '0;
            tck_q      <= 1'b0;
            tms_q      <= 1'b1;
            tdi_q      <= 1'b1;
            tdo_valid  <= 1'b0;
            tdo_bit    <= 1'b0;
            tdo_driven <= 1'b0;
        end else begin
            tdo_valid <= 1'b0;
            cnt_q     <= cnt_q + 1'b1;
            case (hs_q)
                HS_IDLE: begin
                    cnt_q <= '0;
                end
                HS_LOW: begin
                    if (half_done) begin
                        hs_q       <= HS_HIGH;
                        cnt_q      <= '0;
                        tck_q      <= 1'b1;
                        tdo_valid  <= 1'b1;
                        tdo_bit    <= tdo2_q[1];
                        tdo_driven <= tdo2_q[0];
                    end
                end
                HS_HIGH: begin
                    if (half_done) begin
                        hs_q  <= HS_IDLE;
                        cnt_q <= '0;
                        tck_q <= 1'b0;
                    end
                end
                default: begin
                    hs_q <= HS_IDLE;
                end
            endcase
            if (take) begin
                hs_q  <= HS_LOW;
                cnt_q <= '0;
                tck_q <= 1'b0;
                tms_q <= q_data[1];
                tdi_q <= q_data[0];
            end
        end
    end

    assign link.tck = tck_q;
    assign link.tms = tms_q;
    assign link.tdi = tdi_q;
endmodule : tap_host
`default_nettype wire

// >>> sim/sram_tap_link_monitor.sv
// Purpose: Link checks between test controller and test port
// Assumes: Link signals arrive as plain inputs in the core clock domain
// Notes:   Counts mode bit runs at test clock rises
`timescale 1ns/1ns
`default_nettype none
module sram_tap_link_monitor
    import tap_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic       tck_q;
    logic       zero_q;
    logic       rise;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [2:0] ones_q;
    logic [2:0] ones_d;

    // Edge detect, half period count and run of high mode bits
    assign rise   = tck && !tck_q;
    assign cnt_d  = (tck != tck_q) ? 8'h00 : cnt_q + 8'(cnt_q != 8'hFF);
    assign ones_d = tms ? ones_q + 3'(ones_q != 3'h7) : 3'h0;

    // Helper state, set by reset: half period count to its maximum, the rest cleared
    always_ff @(posedge core_clk) begin
        tck_q  <= srst ? 1'b0 : tck;
        cnt_q  <= srst ? 8'hFF : cnt_d;
        ones_q <= srst ? 3'h0 : (rise ? ones_d : ones_q);
        zero_q <= srst ? 1'b0 : (rise ? !tms : zero_q);
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_oe_reset;
        $fell(srst) |-> !tdo_oe [*8];
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("data out enabled after reset");
    property p_tdo_hold;
        tck && $past(tck) |-> $stable(tdo) && $stable(tdo_oe);
    endproperty
    a_tdo_hold: assert property (p_tdo_hold) else $error("data out moved while clock high");
    property p_tdo_settle;
        $fell(tck) |-> ($stable(tdo) && $stable(tdo_oe)) [*2];
    endproperty
    a_tdo_settle: assert property (p_tdo_settle) else $error("data out moved too early");
    property p_oe_leave;
        $rose(tck) && tms && tdo_oe |-> tdo_oe [*8] ##[1:14] !tdo_oe;
    endproperty
    a_oe_leave: assert property (p_oe_leave) else $error("enable wrong on leaving shift");
    property p_oe_enter;
        $rose(tdo_oe) |-> zero_q;
    endproperty
    a_oe_enter: assert property (p_oe_enter) else $error("enable rose without shift step");
    property p_reset_quiet;
        $fell(tck) && ones_q >= 3'h5 |-> ##6 !tdo_oe;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("enable on after five ones");
    property p_tck_high;
        $fell(tck) |-> cnt_q == 8'(TCK_HALF_CYC - 1);
    endproperty
    a_tck_high: assert property (p_tck_high) else $error("test clock high time wrong");
    property p_tck_low;
        $rose(tck) |-> cnt_q >= 8'(TCK_HALF_CYC - 1);
    endproperty
    a_tck_low: assert property (p_tck_low) else $error("test clock low time short");
    property p_cmd_stable;
        tck |-> $stable(tms) && $stable(tdi);
    endproperty
    a_cmd_stable: assert property (p_cmd_stable) else $error("mode or data moved at rise");

    c_shift: cover property ($rose(tdo_oe));
    c_five: cover property (ones_q == 3'h5);
    c_leave: cover property ($fell(tdo_oe));
endmodule : sram_tap_link_monitor
`default_nettype wire

// >>> sim/sram_boundary_scan_tap_bench.sv
// Purpose: Bench joining test controller and test port over the link
// Assumes: Wide port; a reference model tracks state, instruction and shift data
// Notes:   One note queued per word, compared at each sample pulse
`timescale 1ns/1ns
`default_nettype none
module sram_boundary_scan_tap_bench;
    import tap_pkg::*;
    localparam logic [31:0] ID = 32'h2468_ACE0; // Arbitrary value, bit 0 clear
    typedef struct packed {logic drv; logic bv; logic chk; logic hiz;} note_s;
    logic                    core_clk, srst, cmd_valid, cmd_tms, cmd_tdi;
    logic                    cmd_ready, tdo_valid, tdo_bit, tdo_driven, outputs_hiz;
    logic                    saw_full;
    logic [BSR_LEN_WIDE-1:0] io_ring, sr;
    logic [31:0]             rng;
    int                      num_errors, n_compared, len;
    instr_t                  ir;
    tap_state_e              st, prev_st;
    note_s                   nt;
    note_s                   got;
    note_s                   notes[$];
    instr_t codes[8] = '{INS_EXTEST, INS_IDCODE, INS_SAMPLE_Z, INS_SAMPLE,
                         INS_BYPASS, INS_SAMPLE, INS_EXTEST, INS_SAMPLE_Z};

    tap_link_if tap_link_if_i ();
    tap_host tap_host_i (.core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid),
        .cmd_tms(cmd_tms), .cmd_tdi(cmd_tdi), .cmd_ready(cmd_ready), .tdo_valid(tdo_valid),
        .tdo_bit(tdo_bit), .tdo_driven(tdo_driven), .link(tap_link_if_i));
    sram_tap_device #(.WIDE(1'b1), .ID_WORD(ID)) sram_tap_device_i (.core_clk(core_clk),
        .srst(srst), .link(tap_link_if_i), .io_ring(io_ring), .outputs_hiz(outputs_hiz));
    sram_tap_link_monitor sram_tap_link_monitor_i (.core_clk(core_clk), .srst(srst),
        .tck(tap_link_if_i.tck), .tms(tap_link_if_i.tms), .tdi(tap_link_if_i.tdi),
        .tdo(tap_link_if_i.tdo), .tdo_oe(tap_link_if_i.tdo_oe));

    // Core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd

    function automatic tap_state_e nxt(input tap_state_e s, input logic m);
        case (s)
            ST_RESET: return m ? ST_RESET : ST_IDLE;
            ST_IDLE, ST_UPDATE_DR, ST_UPDATE_IR: return m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: return m ? ST_SEL_IR : ST_CAPTURE_DR;
            ST_CAPTURE_DR, ST_SHIFT_DR: return m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: return m ? ST_UPDATE_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: return m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: return m ? ST_UPDATE_DR : ST_SHIFT_DR;
            ST_SEL_IR: return m ? ST_RESET : ST_CAPTURE_IR;
            ST_CAPTURE_IR, ST_SHIFT_IR: return m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: return m ? ST_UPDATE_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: return m ? ST_EXIT2_IR : ST_PAUSE_IR;
            default: return m ? ST_UPDATE_IR : ST_SHIFT_IR;
        endcase
    endfunction : nxt

    task automatic check(input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %b expected %b", $time, seen, exp);
        end
    endtask : check

    // Note the expected sample, step the model, then offer the word
    task automatic send(input logic m, input logic d);
        int k;
        nt.drv = (st == ST_SHIFT_IR) || (st == ST_SHIFT_DR);
        nt.bv = sr[0];
        nt.chk = (st == ST_IDLE) && (prev_st == ST_IDLE);
        nt.hiz = (ir == INS_EXTEST) || (ir == INS_SAMPLE_Z);
        notes.push_back(nt);
        case (st)
            ST_RESET: ir = INS_IDCODE;
            ST_CAPTURE_IR: begin
                sr = 73'h1;
                len = IR_W;
            end
            ST_CAPTURE_DR: begin
                sr = (ir == INS_IDCODE) ? 73'(ID | 32'h1) : '0;
                len = (ir == INS_IDCODE) ? ID_W : 1;
                if (ir == INS_EXTEST || ir == INS_SAMPLE_Z || ir == INS_SAMPLE) begin
                    sr = io_ring;
                    len = BSR_LEN_WIDE;
                end
            end
            ST_SHIFT_IR, ST_SHIFT_DR: begin
                sr = sr >> 1;
                sr[len-1] = d;
            end
            ST_UPDATE_IR: ir = sr[2:0];
            default: ;
        endcase
        prev_st = st;
        st = nxt(st, m);
        cmd_valid <= 1'b1;
        cmd_tms <= m;
        cmd_tdi <= d;
        k = 0;
        do begin
            @(posedge core_clk);
            saw_full |= !cmd_ready;
            k++;
        end while (cmd_ready !== 1'b1 && k < 999);
        if (cmd_ready !== 1'b1) check(cmd_ready, 1'b1);
    endtask : send

    task automatic walk(input logic [7:0] m, input int n);
        for (int i = 0; i < n; i++) send(m[i], 1'b0);
    endtask : walk

    // From idle: shift an instruction in, update, rest in idle
    task automatic load_ir(input instr_t c);
        walk(8'h03, 4);
        for (int i = 0; i < IR_W; i++) send(i == IR_W - 1, c[i]);
        walk(8'h01, 4);
    endtask : load_ir

    // From idle: capture, shift n random bits, pause, update, idle
    task automatic scan_dr(input int n);
        logic [31:0] r;
        walk(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            r = rnd();
            send(i == n - 1, r[0]);
        end
        walk(8'h06, 6);
    endtask : scan_dr

    task automatic drain(input string name);
        int k;
        cmd_valid <= 1'b0;
        k = 0;
        while (notes.size() != 0 && k < 9999) begin
            @(posedge core_clk);
            k++;
        end
        check(notes.size() == 0, 1'b1);
        $display("test %s done", name);
    endtask : drain

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // Compare each sample pulse with the oldest note
    always @(posedge core_clk) begin
        if (tdo_valid === 1'b1) begin
            if (notes.size() == 0) begin
                num_errors++;
                $display("mismatch at %0t: pulse with no note", $time);
            end else begin
                got = notes.pop_front();
                check(tdo_driven, got.drv);
                if (got.drv) check(tdo_bit, got.bv);
                if (got.chk) check(outputs_hiz, got.hiz);
            end
        end
    end

    // Main sequence
    initial begin
        srst = 1'b1;
        {cmd_valid, cmd_tms, cmd_tdi, saw_full} = 4'h6;
        io_ring = '0;
        sr = '0;
        {rng, num_errors, n_compared, len} = {32'h0000_9A73, 32'h0, 32'h0, 32'h1};
        st = ST_RESET;
        prev_st = ST_RESET;
        ir = INS_IDCODE;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        check(tap_link_if_i.tdo_oe, 1'b0);
        check(tap_link_if_i.tms, 1'b1);
        walk(8'h00, 1);
        scan_dr(ID_W + 8);
        drain("identify after reset");
        foreach (codes[i]) begin
            io_ring <= 73'({rnd(), rnd(), rnd()});
            load_ir(codes[i]);
            scan_dr(BSR_LEN_WIDE + 8);
            drain("instruction scan");
        end
        load_ir(INS_BYPASS);
        walk(8'h01, 3);
        walk(8'hF8, 8);
        walk(8'h00, 1);
        scan_dr(ID_W + 8);
        drain("reset in mid shift");
        check(saw_full, 1'b1);
        check(cmd_ready, 1'b1);
        complete_run();
    end

    // Watchdog
    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        $display("mismatch at %0t: timeout", $time);
        complete_run();
    end
endmodule : sram_boundary_scan_tap_bench
`default_nettype wire
